//--- rtl/lcdmap_top.sv
// module: display ram map, common scan, pin assignment and control register
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module lcdmap_top (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	input  wire logic [10:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	input  wire logic        i_slow_clk,
	input  wire logic [1:0]  i_geometry_build_option,
	input  wire logic [3:0]  i_bias_ratio_build_option,
	output logic      [31:0] o_com,
	output logic      [63:0] o_seg,
	output logic      [31:0] o_shared_common_segment_pin,
	output logic      [31:0] o_shared_is_common,
	output logic             o_com_oe,
	output logic             o_seg_oe,
	output logic             o_shared_oe,
	output logic      [2:0]  o_gray,
	output logic      [4:0]  o_bias_div_x2,
	output logic             o_bias_valid,
	output logic             o_geometry_valid
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic                           slow_s1_r;
	logic                           slow_s2_r;
	logic                           slow_d_r;
	logic [1:0]                     geo_s1_r;
	logic [1:0]                     geo_r;
	logic [3:0]                     bias_s1_r;
	logic [3:0]                     bias_r;
	logic [4:0]                     ctrl_r;
	logic [7:0]                     rdata_r;
	logic [7:0]                     ram_r [lcdmap_pkg::RAM_DEPTH];
	lcdmap_pkg::lcdmap_state_type   st_r;
	lcdmap_pkg::lcdmap_state_type   st_nxt;
	logic [5:0]                     com_r;
	logic [5:0]                     com_nxt;
	logic [3:0]                     grp_r;
	logic [3:0]                     grp_nxt;
	logic                           started_r;
	logic                           shown_r;
	logic [95:0]                    buf_r;
	logic [95:0]                    seg_show_r;
	logic [5:0]                     show_com_r;
	logic [31:0]                    com_pin_r;
	logic [63:0]                    seg_pin_r;
	logic [31:0]                    shared_pin_r;
	logic [31:0]                    shared_com_r;
	logic                           oe_r;
	logic [4:0]                     bias_div_r;
	logic                           bias_ok_r;
	logic                           load_com;
	logic                           fetch;
	logic                           show;
	logic [31:0]                    shared_line;
	logic [31:0]                    shared_com;
	wire                            drv_en;
	wire                            blank;
	wire                            geo_ok;
	wire                            run;
	wire                            tick;
	wire  [6:0]                     ncom;
	wire  [3:0]                     ngrp;
	wire  [5:0]                     com_wrap;
	wire                            sel_ctrl;
	wire                            sel_stat;
	wire                            sel_ram;
	wire  [9:0]                     bus_idx;
	wire  [7:0]                     stat_word;
	wire  [7:0]                     rd_word;
	wire  [7:0]                     ram_byte;
	wire  [63:0]                    com_line;

	lcdmap_fetch_if fetch_if ();

	lcdmap_addr_map u_map (
		.f (fetch_if.mapper)
	);

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			slow_s1_r <= 1'b0;
			slow_s2_r <= 1'b0;
			slow_d_r  <= 1'b0;
			geo_s1_r  <= 2'h0;
			geo_r     <= 2'h0;
			bias_s1_r <= 4'h0;
			bias_r    <= 4'h0;
		end
		else if (i_ce)
		begin
			slow_s1_r <= i_slow_clk;
			slow_s2_r <= slow_s1_r;
			slow_d_r  <= slow_s2_r;
			geo_s1_r  <= i_geometry_build_option;
			geo_r     <= geo_s1_r;
			bias_s1_r <= i_bias_ratio_build_option;
			bias_r    <= bias_s1_r;
		end
	end

	// ****************************************************************
	// register bus
	// ****************************************************************
	assign sel_ctrl  = (i_addr == lcdmap_pkg::CTRL_OFS);
	assign sel_stat  = (i_addr == lcdmap_pkg::STAT_OFS);
	assign sel_ram   = (i_addr >= lcdmap_pkg::RAM_BASE);
	assign bus_idx   = 10'(i_addr - lcdmap_pkg::RAM_BASE);
	assign stat_word = {geo_ok, shown_r, com_r};
	assign rd_word   = sel_ctrl ? {3'h0, ctrl_r} :
	                   sel_stat ? stat_word :
	                   sel_ram  ? ram_r[bus_idx] : 8'h00;

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			ctrl_r  <= lcdmap_pkg::CTRL_RESET;
			rdata_r <= 8'h00;
		end
		else if (i_ce)
		begin
			if (i_wr && sel_ctrl)
				ctrl_r <= i_wdata[4:0];
			rdata_r <= i_rd ? rd_word : 8'h00;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_ce && i_wr && sel_ram)
			ram_r[bus_idx] <= i_wdata;
	end

	assign o_rdata = rdata_r;

	// ****************************************************************
	// common scan
	// ****************************************************************
	assign drv_en   = ctrl_r[lcdmap_pkg::EN_BIT];
	assign blank    = ctrl_r[lcdmap_pkg::BLANK_BIT];
	assign geo_ok   = (geo_r != lcdmap_pkg::GEO_RSVD);
	assign run      = drv_en && geo_ok;
	assign tick     = slow_s2_r && !slow_d_r;
	assign ncom     = lcdmap_pkg::lcdmap_ncom(geo_r);
	assign ngrp     = lcdmap_pkg::lcdmap_ngrp(geo_r);
	assign com_wrap = ({1'b0, com_r} >= ncom - 7'h01) ? 6'h00 : com_r + 6'h01;

	assign fetch_if.geo = geo_r;
	assign fetch_if.com = com_r;
	assign fetch_if.grp = grp_r;
	assign ram_byte     = ram_r[fetch_if.idx];

	always_comb
	begin
		st_nxt   = st_r;
		load_com = 1'b0;
		fetch    = 1'b0;
		show     = 1'b0;
		if (!run)
			st_nxt = lcdmap_pkg::ST_IDLE;
		else
			case (st_r)
				lcdmap_pkg::ST_IDLE:
				begin
					if (tick)
					begin
						st_nxt   = lcdmap_pkg::ST_FETCH;
						load_com = 1'b1;
					end
				end
				lcdmap_pkg::ST_FETCH:
				begin
					fetch = 1'b1;
					if (grp_r >= ngrp - 4'h1)
						st_nxt = lcdmap_pkg::ST_SHOW;
				end
				lcdmap_pkg::ST_SHOW:
				begin
					show   = 1'b1;
					st_nxt = lcdmap_pkg::ST_IDLE;
				end
				default:
					st_nxt = lcdmap_pkg::ST_IDLE;
			endcase
	end

	assign com_nxt = !run ? 6'h00 : load_com ? (started_r ? com_wrap : 6'h00) : com_r;
	assign grp_nxt = fetch ? grp_r + 4'h1 : 4'h0;

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			st_r      <= lcdmap_pkg::ST_IDLE;
			com_r     <= 6'h00;
			grp_r     <= 4'h0;
			started_r <= 1'b0;
		end
		else if (i_ce)
		begin
			st_r      <= st_nxt;
			com_r     <= com_nxt;
			grp_r     <= grp_nxt;
			started_r <= run && (started_r || load_com);
		end
	end

	// ****************************************************************
	// segment byte gathering
	// ****************************************************************
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			buf_r      <= 96'h0;
			seg_show_r <= 96'h0;
			show_com_r <= 6'h00;
			shown_r    <= 1'b0;
		end
		else if (i_ce)
		begin
			if (load_com)
				buf_r <= 96'h0;
			else if (fetch && fetch_if.hit)
				buf_r[{grp_r, 3'h0} +: 8] <= ram_byte;
			if (show)
			begin
				seg_show_r <= buf_r;
				show_com_r <= com_r;
			end
			shown_r <= run && (shown_r || show);
		end
	end

	// ****************************************************************
	// pin assignment
	// ****************************************************************
	assign com_line = (shown_r && !blank) ? (64'h1 << show_com_r) : 64'h0;

	always_comb
	begin
		shared_line = 32'h0;
		shared_com  = 32'h0;
		for (int k = 0; k < 32; k++)
		begin
			if (geo_r == lcdmap_pkg::GEO_64 || (geo_r == lcdmap_pkg::GEO_48 && k < 16))
			begin
				shared_com[k]  = 1'b1;
				shared_line[k] = com_line[32 + k];
			end
			else
				shared_line[k] = seg_show_r[95 - k];
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			com_pin_r    <= 32'h0;
			seg_pin_r    <= 64'h0;
			shared_pin_r <= 32'h0;
			shared_com_r <= 32'h0;
			oe_r         <= 1'b0;
		end
		else if (i_ce)
		begin
			com_pin_r    <= run ? com_line[31:0] : 32'h0;
			seg_pin_r    <= (run && shown_r) ? seg_show_r[63:0] : 64'h0;
			shared_pin_r <= run ? shared_line : 32'h0;
			shared_com_r <= shared_com;
			oe_r         <= run;
		end
	end

	// ****************************************************************
	// bias and contrast
	// ****************************************************************
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			bias_div_r <= 5'h00;
			bias_ok_r  <= 1'b0;
		end
		else if (i_ce)
		begin
			bias_ok_r  <= (bias_r != 4'h0);
			bias_div_r <= (bias_r != 4'h0) ? lcdmap_pkg::BIAS_OFS_X2 + {1'b0, bias_r} : 5'h00;
		end
	end

	assign o_com                       = com_pin_r;
	assign o_seg                       = seg_pin_r;
	assign o_shared_common_segment_pin = shared_pin_r;
	assign o_shared_is_common          = shared_com_r;
	assign o_com_oe                    = oe_r;
	assign o_seg_oe                    = oe_r;
	assign o_shared_oe                 = oe_r;
	assign o_gray                      = ctrl_r[lcdmap_pkg::GRAY_LSB +: 3];
	assign o_bias_div_x2               = bias_div_r;
	assign o_bias_valid                = bias_ok_r;
	assign o_geometry_valid            = geo_ok;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	ctrl_reset_a: assert property (disable iff (1'b0)
		!i_rst_n |=> (ctrl_r == lcdmap_pkg::CTRL_RESET) && !o_com_oe)
		else $error("control register not at reset value");

	rsvd_geometry_a: assert property (
		(i_ce && geo_r == lcdmap_pkg::GEO_RSVD) |=> !o_com_oe && !o_geometry_valid)
		else $error("reserved geometry drives pins");

	seg_rev_32_a: assert property (
		(i_ce && run && geo_r == lcdmap_pkg::GEO_32)
		|=> o_shared_common_segment_pin[0] == $past(seg_show_r[95]) && o_shared_is_common == 32'h0)
		else $error("shared pin 32 not segment 95");

	com_split_48_a: assert property (
		(i_ce && geo_r == lcdmap_pkg::GEO_48) |=> o_shared_is_common == 32'h0000ffff)
		else $error("48 common split wrong");

	com_all_64_a: assert property (
		(i_ce && geo_r == lcdmap_pkg::GEO_64) |=> o_shared_is_common == 32'hffffffff)
		else $error("64 common shared pins not commons");

	addr_map_a: assert property (
		(fetch && geo_r == lcdmap_pkg::GEO_32) |-> fetch_if.idx
		== 10'(lcdmap_pkg::TOP_32 + {5'h00, com_r} - {2'h0, grp_r, 5'h00} - lcdmap_pkg::RAM_BASE))
		else $error("32 common ram index wrong");

	addr_wide_a: assert property (
		(fetch && geo_r != lcdmap_pkg::GEO_32) |-> fetch_if.idx
		== 10'(lcdmap_pkg::TOP_WIDE + {5'h00, com_r} - {1'h0, grp_r, 6'h00} - lcdmap_pkg::RAM_BASE))
		else $error("wide ram index wrong");

	bias_decode_a: assert property (
		i_ce |=> o_bias_valid == ($past(bias_r) != 4'h0)
		&& (!o_bias_valid || o_bias_div_x2 == 5'h09 + {1'b0, $past(bias_r)}))
		else $error("bias ratio decode wrong");

	gray_write_a: assert property (
		(i_ce && i_wr && sel_ctrl) |=> o_gray == $past(i_wdata[4:2]))
		else $error("contrast field not written");

	blank_com_a: assert property (
		(i_ce && blank) |=> o_com == 32'h0
		&& o_seg == (($past(run) && $past(shown_r)) ? 64'($past(seg_show_r)) : 64'h0))
		else $error("blank did not idle commons");

	disable_off_a: assert property (
		(i_ce && !drv_en) |=> !o_com_oe && !o_seg_oe && o_com == 32'h0 && o_seg == 64'h0)
		else $error("disabled driver still drives");

	slow_start_a: assert property (
		(st_r == lcdmap_pkg::ST_IDLE ##1 st_r == lcdmap_pkg::ST_FETCH) |-> $past(tick))
		else $error("scan started without slow clock edge");

	scan_order_a: assert property (
		(i_ce && load_com && started_r) |=> com_r == $past(com_wrap) && {1'b0, com_r} < ncom)
		else $error("common scan order wrong");

	frame_32_c: cover property (show && geo_r == lcdmap_pkg::GEO_32);
	frame_64_c: cover property (show && geo_r == lcdmap_pkg::GEO_64);
	blank_show_c: cover property (shown_r && blank && drv_en);
	wrap_c: cover property (load_com && started_r && com_wrap == 6'h00);

endmodule

//--- rtl/lcdmap_pkg.sv
// package: register map, field layout and ram mapping of the display driver
package lcdmap_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [10:0] CTRL_OFS   = 11'h000;
	localparam logic [10:0] STAT_OFS   = 11'h001;
	localparam logic [10:0] RAM_BASE   = 11'h580;
	localparam int          RAM_DEPTH  = 640;
	localparam int          EN_BIT     = 0;
	localparam int          BLANK_BIT  = 1;
	localparam int          GRAY_LSB   = 2;
	localparam logic [4:0]  CTRL_RESET = 5'h02;

	// ****************************************************************
	// geometry, bias and address layout
	// ****************************************************************
	localparam logic [1:0]  GEO_32      = 2'h0;
	localparam logic [1:0]  GEO_48      = 2'h1;
	localparam logic [1:0]  GEO_64      = 2'h2;
	localparam logic [1:0]  GEO_RSVD    = 2'h3;
	localparam logic [6:0]  NCOM_32     = 7'h20;
	localparam logic [6:0]  NCOM_48     = 7'h30;
	localparam logic [6:0]  NCOM_64     = 7'h40;
	localparam logic [3:0]  NGRP_32     = 4'hc;
	localparam logic [3:0]  NGRP_48     = 4'ha;
	localparam logic [3:0]  NGRP_64     = 4'h8;
	localparam logic [10:0] TOP_32      = 11'h7e0;
	localparam logic [10:0] STEP_32     = 11'h020;
	localparam logic [10:0] TOP_WIDE    = 11'h7c0;
	localparam logic [10:0] STEP_WIDE   = 11'h040;
	localparam logic [4:0]  BIAS_OFS_X2 = 5'h09;

	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SHOW} lcdmap_state_type;

	function automatic logic [6:0] lcdmap_ncom(input logic [1:0] geo);
		return (geo == GEO_32) ? NCOM_32 : (geo == GEO_48) ? NCOM_48 : NCOM_64;
	endfunction

	function automatic logic [3:0] lcdmap_ngrp(input logic [1:0] geo);
		return (geo == GEO_32) ? NGRP_32 : (geo == GEO_48) ? NGRP_48 : NGRP_64;
	endfunction

	// ram index of the byte holding group grp of common com
	function automatic logic [9:0] lcdmap_ram_idx(input logic [1:0] geo,
		input logic [5:0] com, input logic [3:0] grp);
		logic [10:0] top;
		logic [10:0] step;
		logic [10:0] addr;
		top  = (geo == GEO_32) ? TOP_32 : TOP_WIDE;
		step = (geo == GEO_32) ? STEP_32 : STEP_WIDE;
		addr = top + {5'h00, com} - 11'(step * {7'h00, grp});
		return 10'(addr - RAM_BASE);
	endfunction

endpackage

//--- rtl/lcdmap_fetch_if.sv
// interface: ram fetch request between scanner and address mapper
`timescale 1ns/10ps
interface lcdmap_fetch_if;
	logic [1:0] geo;
	logic [5:0] com;
	logic [3:0] grp;
	logic [9:0] idx;
	logic       hit;
	modport requester (output geo, com, grp, input idx, hit);
	modport mapper (input geo, com, grp, output idx, hit);
endinterface

//--- rtl/lcdmap_addr_map.sv
// module: maps geometry, common and segment group onto a display ram index
`timescale 1ns/10ps
module lcdmap_addr_map (
	lcdmap_fetch_if.mapper f
);
	wire geo_ok;
	wire com_ok;
	wire grp_ok;

	assign geo_ok = (f.geo != lcdmap_pkg::GEO_RSVD);
	assign com_ok = ({1'b0, f.com} < lcdmap_pkg::lcdmap_ncom(f.geo));
	assign grp_ok = (f.grp < lcdmap_pkg::lcdmap_ngrp(f.geo));
	assign f.hit  = geo_ok && com_ok && grp_ok;
	assign f.idx  = lcdmap_pkg::lcdmap_ram_idx(f.geo, f.com, f.grp);
endmodule

//--- tb/lcdmap_panel_model.sv
// passive panel model: rebuilds each shown line from common, segment and shared pins
`timescale 1ns/10ps
module lcdmap_panel_model (
	input  wire logic        i_ref_clk,
	input  wire logic [1:0]  i_geo,
	input  wire logic [31:0] i_com,
	input  wire logic [63:0] i_seg,
	input  wire logic [31:0] i_shared,
	input  wire logic        i_com_oe,
	input  wire logic        i_seg_oe,
	input  wire logic        i_shared_oe,
	output logic             o_line_valid,
	output logic      [6:0]  o_line_com,
	output logic      [95:0] o_line_seg
);
	logic [63:0] com_vec;
	logic [95:0] seg_vec;
	logic [6:0]  com_idx;
	logic [63:0] com_prev_r = '0;

	// ****************************************************************
	// panel wiring of the shared pins, fixed by the panel's geometry
	// ****************************************************************
	always_comb
	begin
		com_vec = {32'h0, i_com & {32{i_com_oe}}};
		seg_vec = {32'h0, i_seg & {64{i_seg_oe}}};
		com_idx = 7'h7f;
		for (int k = 0; k < 32; k++)
		begin
			if (i_geo == 2'h2 || (i_geo == 2'h1 && k < 16))
				com_vec[32 + k] = i_shared[k] & i_shared_oe;
			else
				seg_vec[95 - k] = i_shared[k] & i_shared_oe;
		end
		for (int c = 0; c < 64; c++)
		begin
			if (com_vec == (64'h1 << c))
				com_idx = 7'(c);
		end
	end

	// ****************************************************************
	// a line is seen when a new common becomes active
	// ****************************************************************
	always_ff @(posedge i_ref_clk)
	begin
		com_prev_r   <= com_vec;
		o_line_valid <= (com_vec != com_prev_r) && (com_vec != '0);
		o_line_com   <= com_idx;
		o_line_seg   <= seg_vec;
	end
endmodule

//--- tb/tb_top.sv
// testbench: register port, bias decode, ram map and scan of all geometries
`timescale 1ns/10ps
module tb_top;
	logic        i_ref_clk = 1'b0;
	logic        i_rst_n, i_ce, i_wr, i_rd, i_slow_clk;
	logic [10:0] i_addr;
	logic [7:0]  i_wdata;
	logic [1:0]  i_geometry_build_option;
	logic [3:0]  i_bias_ratio_build_option;
	logic [7:0]  o_rdata;
	logic [31:0] o_com, o_shared_common_segment_pin, o_shared_is_common;
	logic [63:0] o_seg;
	logic        o_com_oe, o_seg_oe, o_shared_oe, o_bias_valid, o_geometry_valid;
	logic [2:0]  o_gray;
	logic [4:0]  o_bias_div_x2;
	logic        line_valid;
	logic [6:0]  line_com;
	logic [95:0] line_seg;
	logic        rd_p1 = 1'b0;
	logic [7:0]  ram_m [0:2047];
	logic [7:0]  rd_q [$];
	logic [102:0] line_q [$];
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          rnd;

	always #4 i_ref_clk = ~i_ref_clk;

	lcdmap_top dut_u (.i_ref_clk, .i_rst_n, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_slow_clk, .i_geometry_build_option, .i_bias_ratio_build_option, .o_com, .o_seg,
		.o_shared_common_segment_pin, .o_shared_is_common, .o_com_oe, .o_seg_oe,
		.o_shared_oe, .o_gray, .o_bias_div_x2, .o_bias_valid, .o_geometry_valid);

	lcdmap_panel_model panel_u (.i_ref_clk, .i_geo(i_geometry_build_option), .i_com(o_com),
		.i_seg(o_seg), .i_shared(o_shared_common_segment_pin), .i_com_oe(o_com_oe),
		.i_seg_oe(o_seg_oe), .i_shared_oe(o_shared_oe), .o_line_valid(line_valid),
		.o_line_com(line_com), .o_line_seg(line_seg));

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask

	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		step(1);
		i_wr    <= 1'b0;
		step(1);
	endtask

	task automatic rd(input logic [10:0] a, input logic [7:0] exp);
		rd_q.push_back(exp);
		i_addr <= a;
		i_rd   <= 1'b1;
		step(1);
		i_rd   <= 1'b0;
		step(1);
	endtask

	// one slow clock period, far slower than a line fetch
	task automatic tick;
		i_slow_clk <= 1'b1;
		step(4);
		i_slow_clk <= 1'b0;
		step(26);
	endtask

	function automatic logic [95:0] exp_seg(input int g, input int n);
		logic [95:0] v = '0;
		int ng = (g == 0) ? 12 : (g == 1) ? 10 : 8;
		for (int q = 0; q < ng; q++)
			v[q*8 +: 8] = ram_m[(g == 0) ? 'h7e0 + n - 'h20*q : 'h7c0 + n - 'h40*q];
		return v;
	endfunction

	task automatic run_geo(input int g);
		int nc;
		int lo;
		nc = (g == 0) ? 32 : (g == 1) ? 48 : 64;
		lo = (g == 0) ? 'h680 : (g == 1) ? 'h580 : 'h600;
		wr(11'h000, 8'h00);
		step(2);
		check({o_com, o_seg, o_shared_common_segment_pin}, '0);
		check({o_com_oe, o_seg_oe, o_shared_oe}, 3'h0);
		i_geometry_build_option <= 2'(g);
		for (int a = lo; a < 'h800; a++)
		begin
			ram_m[a] = 8'($urandom);
			wr(11'(a), ram_m[a]);
		end
		rd(11'(lo), ram_m[lo]);
		wr(11'h000, 8'h01);
		step(40);
		check(o_com, 32'h0);
		check(o_shared_is_common, (g == 0) ? 32'h0 : (g == 1) ? 32'hffff : 32'hffffffff);
		check(o_geometry_valid, 1'b1);
		for (int i = 0; i <= nc; i++)
		begin
			if (g == 0 && i == 2)
			begin
				wr(11'h000, 8'h03);
				tick;
				check({o_com_oe, o_com}, {1'b1, 32'h0});
				check(o_seg, exp_seg(0, 2) & 96'hffffffffffffffff);
				// unblanking brings common 2 back onto the panel with the same segments
				line_q.push_back({7'h02, exp_seg(0, 2)});
				wr(11'h000, 8'h01);
			end
			else
			begin
				line_q.push_back({7'(i % nc), exp_seg(g, i % nc)});
				tick;
			end
		end
		$display("test geometry %0d done", g);
	endtask

	// ****************************************************************
	// result monitor
	// ****************************************************************
	always @(posedge i_ref_clk)
	begin
		if (rd_p1)
			check(o_rdata, (rd_q.size() != 0) ? rd_q.pop_front() : 8'hxx);
		rd_p1 <= i_rd;
		if (line_valid)
			check({line_com, line_seg}, (line_q.size() != 0) ? line_q.pop_front() : 'x);
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		i_rst_n = 1'b0;
		i_ce = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_slow_clk = 1'b0;
		i_addr = 11'h000;
		i_wdata = 8'h00;
		i_geometry_build_option = 2'h0;
		i_bias_ratio_build_option = 4'h5;
		rnd = $urandom(36);
		step(3);
		i_rst_n <= 1'b1;
		step(1);
		rd(11'h000, 8'h02);
		rd(11'h001, 8'h80);
		rd(11'h123, 8'h00);
		wr(11'h000, 8'hff);
		rd(11'h000, 8'h1f);
		check(o_gray, 3'h7);
		wr(11'h000, 8'h00);
		check(o_gray, 3'h0);
		$display("test register done");
		for (int b = 0; b < 16; b++)
		begin
			i_bias_ratio_build_option <= 4'(b);
			step(6);
			check({o_bias_valid, o_bias_div_x2}, (b == 0) ? 6'h00 : {1'b1, 5'(b + 9)});
		end
		$display("test bias done");
		for (int g = 0; g < 3; g++)
			run_geo(g);
		i_geometry_build_option <= 2'h3;
		step(4);
		tick;
		check({o_geometry_valid, o_com_oe, o_seg_oe, o_shared_oe}, 4'h0);
		$display("test reserved geometry done");
		wr(11'h000, 8'h00);
		for (int w = 0; w < 2000 && (line_q.size() != 0 || rd_q.size() != 0); w++)
			step(1);
		if (line_q.size() != 0 || rd_q.size() != 0)
			n_mismatch++;
		report_and_stop;
	end
endmodule
